/* agpio_top.sv */
// general pin, sync/error pin and external multiplexer control behind the pin config register
`timescale 1ns/1ns
`include "agpio_params.svh"
module agpio_top
  import agpio_pkg::*;
#(
  parameter int DLY_W = 8,
  parameter int ERR_W = 4
) (
  input wire logic core_clk, // block clock, 25 MHz
  input wire logic sys_rst, // async reset, active high
  input wire logic [7:0] regAddr, // register address from serial interface
  input wire agpio_pkg::agpio_word_t regWrData, // write data
  input wire logic regWrEn, // write strobe, one cycle
  input wire logic regRdEn, // read strobe, one cycle
  output agpio_pkg::agpio_word_t regRdData, // read data, registered
  output logic regRdValid, // read data valid, one cycle
  input wire logic [1:0] seqChannel, // channel the sequencer switches to
  input wire logic seqSwitchDue, // channel switch due, one cycle
  input wire logic multiChanEn, // more than one channel enabled
  input wire logic altSyncMode, // alternate_sync_mode from interface mode
  input wire logic [DLY_W-1:0] muxDelay, // wait cycles after a mux switch
  input wire logic [ERR_W-1:0] statusErrBits, // status register error bits
  output logic filterResetHold, // hold modulator and filter in reset
  output logic convStart, // begin next conversion, one cycle
  output logic adcErrorFlag, // contribution to converter error flag
  input wire logic [1:0] generalPinIn, // general_pin_1/0 pad levels
  output logic [1:0] generalPinOut, // general pin drive levels
  output logic [1:0] generalPinOe, // general pin drive enables
  input wire logic errPinIn, // sync/error pad level
  output logic errPinOut, // sync/error drive level
  output logic errPinOe // sync/error drive enable
);
  import agpio_pkg::*;
  // ----------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------
  logic [2:0] pinSync;
  logic syncLevel;
  logic [1:0] genLevel;

  agpio_sync #(.WIDTH(3)) u_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pinAsync({errPinIn, generalPinIn}),
    .pinSync(pinSync)
  );
  assign syncLevel = pinSync[2];
  assign genLevel = pinSync[1:0];
  // ----------------------------------------------------------------
  // configuration register
  // ----------------------------------------------------------------
  agpio_word_t generalIoConfig_q, generalIoConfig_d;
  agpio_word_t regRdData_q, regRdData_d;
  logic regRdValid_q, regRdValid_d;
  logic extMuxDrive, syncInputEnable, errorPinLevel;
  logic [1:0] pinInputEnable, pinOutputEnable, pinLevel;
  agpio_err_mode_t errMode;
  logic cfgHit;

  assign extMuxDrive = generalIoConfig_q[`AGPIO_BIT_EXT_MUX];
  assign syncInputEnable = generalIoConfig_q[`AGPIO_BIT_SYNC_EN];
  assign errMode = agpio_err_mode_t'(generalIoConfig_q[`AGPIO_BIT_ERR_HI:`AGPIO_BIT_ERR_LO]);
  assign errorPinLevel = generalIoConfig_q[`AGPIO_BIT_ERR_LVL];
  assign pinInputEnable = {generalIoConfig_q[`AGPIO_BIT_IN_EN1],
                           generalIoConfig_q[`AGPIO_BIT_IN_EN0]};
  assign pinOutputEnable = {generalIoConfig_q[`AGPIO_BIT_OUT_EN1],
                            generalIoConfig_q[`AGPIO_BIT_OUT_EN0]};
  assign pinLevel = {generalIoConfig_q[`AGPIO_BIT_LVL1], generalIoConfig_q[`AGPIO_BIT_LVL0]};
  assign cfgHit = (regAddr == `AGPIO_CFG_ADDR);
  // a pin set as input reports the synchronised pad, otherwise the written value
  function automatic logic readLevel(input logic isInput, input logic padLvl,
                                     input logic stored);
    readLevel = isInput ? padLvl : stored;
  endfunction
  // writes store only defined bits; unmapped addresses read zero
  always_comb begin
    generalIoConfig_d = generalIoConfig_q;
    regRdData_d = regRdData_q;
    regRdValid_d = regRdEn;
    if (regWrEn && cfgHit) begin
      generalIoConfig_d = regWrData & `AGPIO_CFG_WMASK;
    end
    if (regRdEn) begin
      regRdData_d = '0;
      if (cfgHit) begin
        regRdData_d = generalIoConfig_q & `AGPIO_CFG_WMASK;
        regRdData_d[`AGPIO_BIT_ERR_LVL] = readLevel(errMode == AGPIO_ERR_IN, syncLevel,
                                                    errorPinLevel);
        regRdData_d[`AGPIO_BIT_LVL1] = readLevel(pinInputEnable[1], genLevel[1],
                                                 pinLevel[1]);
        regRdData_d[`AGPIO_BIT_LVL0] = readLevel(pinInputEnable[0], genLevel[0],
                                                 pinLevel[0]);
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      generalIoConfig_q <= `AGPIO_CFG_RESET;
      regRdData_q <= '0;
      regRdValid_q <= 1'b0;
    end else begin
      generalIoConfig_q <= generalIoConfig_d;
      regRdData_q <= regRdData_d;
      regRdValid_q <= regRdValid_d;
    end
  end

  assign regRdData = regRdData_q;
  assign regRdValid = regRdValid_q;
  // ----------------------------------------------------------------
  // channel switch sequencing
  // ----------------------------------------------------------------
  agpio_seq_state_t seqState_q, seqState_d;
  logic [DLY_W-1:0] waitCnt_q, waitCnt_d;
  logic [1:0] muxSel_q, muxSel_d;
  logic convStart_q, convStart_d;
  logic altActive, blockSwitch;

  // alternate sync only takes effect while several channels are enabled
  assign altActive = syncInputEnable && altSyncMode && multiChanEn;
  assign blockSwitch = altActive && !syncLevel;
  // the select latches on the switch itself so the mux settles during the wait
  always_comb begin
    seqState_d = seqState_q;
    waitCnt_d = waitCnt_q;
    muxSel_d = muxSel_q;
    convStart_d = 1'b0;
    unique case (seqState_q)
      SEQ_IDLE: begin
        if (seqSwitchDue) begin
          muxSel_d = seqChannel;
          if (blockSwitch) begin
            seqState_d = SEQ_HOLD;
          end else if (muxDelay != '0) begin
            waitCnt_d = muxDelay;
            seqState_d = SEQ_WAIT;
          end else begin
            convStart_d = 1'b1;
          end
        end
      end
      SEQ_HOLD: begin
        if (!altActive || syncLevel) begin
          if (muxDelay != '0) begin
            waitCnt_d = muxDelay;
            seqState_d = SEQ_WAIT;
          end else begin
            convStart_d = 1'b1;
            seqState_d = SEQ_IDLE;
          end
        end
      end
      SEQ_WAIT: begin
        if (waitCnt_q <= DLY_W'(1)) begin
          convStart_d = 1'b1;
          seqState_d = SEQ_IDLE;
        end else begin
          waitCnt_d = waitCnt_q - DLY_W'(1);
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      seqState_q <= SEQ_IDLE;
      waitCnt_q <= '0;
      muxSel_q <= 2'h0;
      convStart_q <= 1'b0;
    end else begin
      seqState_q <= seqState_d;
      waitCnt_q <= waitCnt_d;
      muxSel_q <= muxSel_d;
      convStart_q <= convStart_d;
    end
  end

  assign convStart = convStart_q;
  // ----------------------------------------------------------------
  // pin drive, error flag and filter hold
  // ----------------------------------------------------------------
  logic [1:0] genOut_q, genOut_d, genOe_q, genOe_d;
  logic errOut_q, errOut_d, errOe_q, errOe_d;
  logic hold_q, hold_d, errFlag_q, errFlag_d;

  // outputs are registered so pads never see decode glitches
  always_comb begin
    // plain sync holds while low; alternate mode leaves the filter running
    hold_d = syncInputEnable && !altActive && !syncLevel;
    if (extMuxDrive) begin
      genOut_d = muxSel_q;
      genOe_d = 2'b11;
    end else begin
      genOut_d = pinLevel;
      genOe_d = pinOutputEnable & ~pinInputEnable;
    end
    errOut_d = 1'b0;
    errOe_d = 1'b0;
    errFlag_d = 1'b0;
    unique case (errMode)
      AGPIO_ERR_OFF: errFlag_d = 1'b0;
      AGPIO_ERR_IN: errFlag_d = !syncLevel;
      AGPIO_ERR_OD: errOe_d = |statusErrBits;
      AGPIO_ERR_OUT: begin
        errOut_d = errorPinLevel;
        errOe_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      genOut_q <= 2'h0;
      genOe_q <= 2'h0;
      errOut_q <= 1'b0;
      errOe_q <= 1'b0;
      hold_q <= 1'b0;
      errFlag_q <= 1'b0;
    end else begin
      genOut_q <= genOut_d;
      genOe_q <= genOe_d;
      errOut_q <= errOut_d;
      errOe_q <= errOe_d;
      hold_q <= hold_d;
      errFlag_q <= errFlag_d;
    end
  end

  assign generalPinOut = genOut_q;
  assign generalPinOe = genOe_q;
  assign errPinOut = errOut_q;
  assign errPinOe = errOe_q;
  assign filterResetHold = hold_q;
  assign adcErrorFlag = errFlag_q;
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence muxSwitch_s;
    seqState_q == SEQ_IDLE && seqSwitchDue ##1 extMuxDrive;
  endsequence
  mux_select_a: assert property (muxSwitch_s |=> generalPinOut == $past(seqChannel, 2))
    else $error("mux select not driven from switched channel");
  wait_hold_a: assert property ((seqState_q == SEQ_WAIT && waitCnt_q > DLY_W'(1))
      |=> !convStart && seqState_q == SEQ_WAIT)
    else $error("conversion started before mux wait elapsed");
  sync_hold_a: assert property ((syncInputEnable && !altActive && !syncLevel)
      |=> filterResetHold)
    else $error("low sync did not hold filter");
  alt_block_a: assert property ((seqState_q == SEQ_IDLE && seqSwitchDue && blockSwitch)
      |=> seqState_q == SEQ_HOLD && !convStart && !filterResetHold)
    else $error("alternate sync did not block switch");
  alt_release_a: assert property ((seqState_q == SEQ_HOLD && syncLevel && muxDelay == '0)
      |=> convStart && seqState_q == SEQ_IDLE)
    else $error("sync rise did not start conversion");
  err_off_a: assert property (errMode == AGPIO_ERR_OFF |=> !adcErrorFlag)
    else $error("error flag set while error function off");
  err_input_a: assert property (errMode == AGPIO_ERR_IN |=> adcErrorFlag == !$past(syncLevel))
    else $error("error input not inverted into flag");
  err_drain_a: assert property (errMode == AGPIO_ERR_OD
      |=> !errPinOut && errPinOe == $past(|statusErrBits))
    else $error("open-drain error pin wrong");
  err_gpo_a: assert property (errMode == AGPIO_ERR_OUT
      |=> errPinOe && errPinOut == $past(errorPinLevel))
    else $error("error pin output level wrong");
  lvl_read_a: assert property ((regRdEn && cfgHit && errMode == AGPIO_ERR_IN)
      |=> regRdValid && regRdData[`AGPIO_BIT_ERR_LVL] == $past(syncLevel))
    else $error("pin-level bit does not show pin");
  gen_input_a: assert property ((!extMuxDrive && pinInputEnable[0]) |=> !generalPinOe[0])
    else $error("input pin is driven");
  gen_output_a: assert property ((!extMuxDrive && pinOutputEnable[1] && !pinInputEnable[1])
      |=> generalPinOe[1] && generalPinOut[1] == $past(pinLevel[1]))
    else $error("output pin not driven with data bit");
  rsvd_zero_a: assert property (regRdValid |-> (regRdData & ~`AGPIO_CFG_WMASK) == '0)
    else $error("reserved bits read nonzero");
endmodule // agpio_top

/* agpio_params.svh */
// register map, field positions, reset values and bit masks of the pin control block
`ifndef AGPIO_PARAMS_SVH
`define AGPIO_PARAMS_SVH

`define AGPIO_CFG_ADDR 8'h06
`define AGPIO_CFG_RESET 16'h0800
`define AGPIO_CFG_WMASK 16'h1f3f
`define AGPIO_BIT_EXT_MUX 12
`define AGPIO_BIT_SYNC_EN 11
`define AGPIO_BIT_ERR_HI 10
`define AGPIO_BIT_ERR_LO 9
`define AGPIO_BIT_ERR_LVL 8
`define AGPIO_BIT_IN_EN1 5
`define AGPIO_BIT_IN_EN0 4
`define AGPIO_BIT_OUT_EN1 3
`define AGPIO_BIT_OUT_EN0 2
`define AGPIO_BIT_LVL1 1
`define AGPIO_BIT_LVL0 0
`define AGPIO_SYNC_STAGES 2

`endif

/* agpio_pkg.sv */
// types shared by the pin control block
package agpio_pkg;
  // encoding of the error-function field of the configuration register
  typedef enum logic [1:0] {
    AGPIO_ERR_OFF = 2'h0,
    AGPIO_ERR_IN = 2'h1,
    AGPIO_ERR_OD = 2'h2,
    AGPIO_ERR_OUT = 2'h3
  } agpio_err_mode_t;

  // channel-switch sequencing states
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_HOLD,
    SEQ_WAIT
  } agpio_seq_state_t;

  typedef logic [15:0] agpio_word_t;
endpackage

/* agpio_sync.sv */
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ns
`include "agpio_params.svh"
module agpio_sync #(
  parameter int WIDTH = 3
) (
  input wire logic core_clk, // block clock
  input wire logic sys_rst, // async reset, active high
  input wire logic [WIDTH-1:0] pinAsync, // raw pin levels
  output logic [WIDTH-1:0] pinSync // levels in the clock domain
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] stable_q;

  // first stage feeds only the second stage, never any logic
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= '0;
      stable_q <= '0;
    end else begin
      meta_q <= pinAsync;
      stable_q <= meta_q;
    end
  end

  assign pinSync = stable_q;
endmodule // agpio_sync

/* agpio_pad_model.sv */
// pad model: pull-up on the shared sync/error line and an outside source on the general pins
`timescale 1ns/1ns
module agpio_pad_model (
  input wire logic core_clk, // block clock
  input wire logic [1:0] generalPinOut, // device drive levels
  input wire logic [1:0] generalPinOe, // device drive enables
  input wire logic errPinOut, // device sync/error level
  input wire logic errPinOe, // device sync/error enable
  input wire logic [1:0] extLevel, // level of the outside source
  input wire logic [1:0] extEn, // outside source drives the pin
  input wire logic extErrLow, // another party pulls the shared line low
  output logic [1:0] generalPinIn, // resolved general pin levels
  output logic errPinIn // resolved sync/error level
);
  logic [1:0] floatLvl = 2'h1;
  // a general pin has no pull, so an undriven pin toggles and never looks valid
  always @(posedge core_clk) begin
    floatLvl <= ~floatLvl;
  end
  // device drive wins, then the outside source, then the float pattern
  assign generalPinIn = (generalPinOe & generalPinOut) | (~generalPinOe & extEn & extLevel)
    | (~generalPinOe & ~extEn & floatLvl);
  // wired line: pulled up unless any party drives it low
  assign errPinIn = ~(extErrLow | (errPinOe & ~errPinOut));
endmodule // agpio_pad_model

/* agpio_top_bench.sv */
// self-checking bench of the pin control block
`timescale 1ns/1ns
`include "agpio_params.svh"
module agpio_top_bench;
  import agpio_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] regAddr = 8'h0;
  agpio_word_t regWrData = 16'h0;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  agpio_word_t regRdData;
  logic regRdValid, filterResetHold, convStart, adcErrorFlag, errPinIn, errPinOut, errPinOe;
  logic [1:0] seqChannel = 2'h0;
  logic seqSwitchDue = 1'b0;
  logic multiChanEn = 1'b0;
  logic altSyncMode = 1'b0;
  logic [7:0] muxDelay = 8'h0;
  logic [3:0] statusErrBits = 4'h0;
  logic [1:0] generalPinIn, generalPinOut, generalPinOe;
  logic [1:0] extLevel = 2'h0;
  logic [1:0] extEn = 2'h0;
  logic extErrLow = 1'b0;
  logic seen;
  int badCount = 0;
  int checkCount = 0;

  always #20 core_clk = ~core_clk;

  agpio_top agpio_top_inst (.core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .regRdValid(regRdValid), .seqChannel(seqChannel), .seqSwitchDue(seqSwitchDue),
    .multiChanEn(multiChanEn), .altSyncMode(altSyncMode), .muxDelay(muxDelay),
    .statusErrBits(statusErrBits), .filterResetHold(filterResetHold), .convStart(convStart),
    .adcErrorFlag(adcErrorFlag), .generalPinIn(generalPinIn), .generalPinOut(generalPinOut),
    .generalPinOe(generalPinOe), .errPinIn(errPinIn), .errPinOut(errPinOut),
    .errPinOe(errPinOe));

  agpio_pad_model agpio_pad_model_inst (.core_clk(core_clk), .generalPinOut(generalPinOut),
    .generalPinOe(generalPinOe), .errPinOut(errPinOut), .errPinOe(errPinOe),
    .extLevel(extLevel), .extEn(extEn), .extErrLow(extErrLow), .generalPinIn(generalPinIn),
    .errPinIn(errPinIn));

  // --------------------------------------------------------------
  // access and compare tasks
  // --------------------------------------------------------------
  // every drive lands 1 ns after the rising edge, clear of the sampling edge
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checkCount++;
    if (got !== exp) begin
      badCount++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // write then wait long enough for config and pin flops to follow
  task automatic wr(input logic [15:0] data);
    regAddr = `AGPIO_CFG_ADDR;
    regWrData = data;
    regWrEn = 1'b1;
    step(1);
    regWrEn = 1'b0;
    step(3);
  endtask

  // valid must come exactly one edge after the strobe and stand for one cycle only
  task automatic rd(input logic [7:0] addr, input logic [15:0] exp);
    regAddr = addr;
    regRdEn = 1'b1;
    step(1);
    regRdEn = 1'b0;
    chk({15'h0, regRdValid}, 16'h1);
    chk(regRdData, exp);
    step(1);
    chk({15'h0, regRdValid}, 16'h0);
  endtask

  // one channel switch; edges counted from the taking edge to the conversion start
  task automatic sw(input logic [1:0] ch, input int expEdges);
    int n;
    seqChannel = ch;
    seqSwitchDue = 1'b1;
    step(1);
    seqSwitchDue = 1'b0;
    n = 1;
    while (convStart !== 1'b1 && n < 12) begin
      step(1);
      n++;
    end
    chk(16'(n), 16'(expEdges));
  endtask

  task automatic wrapUp;
    if (badCount == 0 && checkCount > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // --------------------------------------------------------------
  // test sequence
  // --------------------------------------------------------------
  initial begin
    repeat (4) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    step(4);
    rd(`AGPIO_CFG_ADDR, `AGPIO_CFG_RESET);
    chk({14'h0, generalPinOe}, 16'h0);
    rd(8'h05, 16'h0);
    // reserved bits written as ones must be dropped
    wr(16'he0cf);
    chk({12'h0, generalPinOe, generalPinOut}, 16'h000f);
    rd(`AGPIO_CFG_ADDR, 16'h000f);
    extEn = 2'h3;
    extLevel = 2'h1;
    wr(16'h0032);
    step(2);
    chk({14'h0, generalPinOe}, 16'h0);
    rd(`AGPIO_CFG_ADDR, 16'h0031);
    wr(16'h002c);
    chk({14'h0, generalPinOe}, 16'h1);
    rd(`AGPIO_CFG_ADDR, 16'h002c);
    extEn = 2'h0;
    // error field off ignores a low pin
    extErrLow = 1'b1;
    wr(16'h0100);
    step(2);
    chk({14'h0, errPinOe, adcErrorFlag}, 16'h0);
    wr(16'h0200);
    step(2);
    chk({15'h0, adcErrorFlag}, 16'h1);
    rd(`AGPIO_CFG_ADDR, 16'h0200);
    extErrLow = 1'b0;
    step(4);
    chk({15'h0, adcErrorFlag}, 16'h0);
    rd(`AGPIO_CFG_ADDR, 16'h0300);
    wr(16'h0400);
    chk({15'h0, errPinOe}, 16'h0);
    statusErrBits = 4'h2;
    step(2);
    chk({13'h0, errPinOe, errPinOut, errPinIn}, 16'h4);
    statusErrBits = 4'h0;
    wr(16'h0700);
    chk({14'h0, errPinOe, errPinOut}, 16'h3);
    wr(16'h0600);
    chk({14'h0, errPinOe, errPinOut}, 16'h2);
    // plain sync hold follows the pin level
    wr(16'h0800);
    extErrLow = 1'b1;
    step(4);
    chk({15'h0, filterResetHold}, 16'h1);
    extErrLow = 1'b0;
    step(4);
    chk({15'h0, filterResetHold}, 16'h0);
    // external multiplexer select follows every channel
    wr(16'h1000);
    for (int c = 0; c < 4; c++) begin
      sw(2'(c), 1);
      step(1);
      chk({12'h0, generalPinOe, generalPinOut}, 16'(12 + c));
    end
    muxDelay = 8'h2;
    sw(2'h2, 3);
    muxDelay = 8'h5;
    sw(2'h1, 6);
    muxDelay = 8'h0;
    // alternate sync only blocks the due switch
    wr(16'h1800);
    altSyncMode = 1'b1;
    multiChanEn = 1'b1;
    extErrLow = 1'b1;
    step(4);
    chk({15'h0, filterResetHold}, 16'h0);
    seqChannel = 2'h3;
    seqSwitchDue = 1'b1;
    step(1);
    seqSwitchDue = 1'b0;
    seen = 1'b0;
    for (int i = 0; i < 6; i++) begin
      seen = seen | convStart;
      step(1);
    end
    chk({15'h0, seen}, 16'h0);
    extErrLow = 1'b0;
    for (int i = 0; i < 6 && convStart !== 1'b1; i++) begin
      step(1);
    end
    chk({15'h0, convStart}, 16'h1);
    // a blocked switch released by the pin still waits out the mux delay
    muxDelay = 8'h2;
    extErrLow = 1'b1;
    step(3);
    seqSwitchDue = 1'b1;
    step(1);
    seqSwitchDue = 1'b0;
    extErrLow = 1'b0;
    step(4);
    chk({15'h0, convStart}, 16'h0);
    step(1);
    chk({15'h0, convStart}, 16'h1);
    wrapUp();
  end

  // watchdog well beyond the roughly 130 cycles the sequence needs
  initial begin
    #(40 * 4000);
    badCount++;
    wrapUp();
  end
endmodule // agpio_top_bench
